/* core/mrs_pkg.sv */
// Notes on behaviour
// - Read analog inputs needs nonzero address and count 1 to 125.
// - Analog reply byte count is twice the count, 2 to 250.
// - Analog start is first input minus one; start plus count within table.
// - Every two-byte field travels high byte first, low byte second.
// - Analog values return in ascending order, lowest number first.
// - Address zero on functions 5, 6, 15 or restart executes silently.
// - Single force data is 00 (off) or FF (on), then 00; point is number minus one.
// - Addressed single force is answered by an exact echo.
// - Forced outputs are only guaranteed at the start of one program sweep.
// - Preset single writes the value into register field plus one, then echoes.
// - Exception status returns outputs one to eight, point one in bit 0.
// - Diagnostic function carries a two-byte code; only 0, 1 and 4 exist.
// - Diagnostic 0 with nonzero address echoes any data.
// - Diagnostic 1 leaves listen-only; data other than 0000 or FF00 gives error, else echo.
// - Diagnostic 4 with zero data enters listen-only and never answers.
// - Listen-only executes nothing and answers nothing until restart or reset.
// - Multiple force byte count is 1 to 256, zero meaning 256.
// - Multiple force data packs eight points per byte, first point in bit 0.
// - Multiple force start is first output minus one; range within table.
package mrs_pkg;

  // ****************************************
  // Table sizes
  // ****************************************
  localparam int unsigned MRS_NUM_OUT    = 256;
  localparam int unsigned MRS_NUM_AI     = 128;
  localparam int unsigned MRS_NUM_REG    = 64;
  localparam logic [15:0] MRS_MAX_AI_CNT = 16'h007D;

  // ****************************************
  // Function and diagnostic codes
  // ****************************************
  localparam logic [7:0]  MRS_FN_RD_AI    = 8'h04;
  localparam logic [7:0]  MRS_FN_FORCE1   = 8'h05;
  localparam logic [7:0]  MRS_FN_PRESET1  = 8'h06;
  localparam logic [7:0]  MRS_FN_EXC_ST   = 8'h07;
  localparam logic [7:0]  MRS_FN_DIAG     = 8'h08;
  localparam logic [7:0]  MRS_FN_FORCE_N  = 8'h0F;
  localparam logic [15:0] MRS_DG_ECHO     = 16'h0000;
  localparam logic [15:0] MRS_DG_RESTART  = 16'h0001;
  localparam logic [15:0] MRS_DG_LISTEN   = 16'h0004;
  localparam logic [7:0]  MRS_DATA_ON     = 8'hFF;
  localparam logic [7:0]  MRS_DATA_OFF    = 8'h00;

  // ****************************************
  // Byte positions and lengths
  // ****************************************
  localparam logic [8:0]  MRS_POS_ADDR    = 9'h000;
  localparam logic [8:0]  MRS_POS_FUNC    = 9'h001;
  localparam logic [8:0]  MRS_POS_F1_HI   = 9'h002;
  localparam logic [8:0]  MRS_POS_F1_LO   = 9'h003;
  localparam logic [8:0]  MRS_POS_F2_HI   = 9'h004;
  localparam logic [8:0]  MRS_POS_F2_LO   = 9'h005;
  localparam logic [8:0]  MRS_POS_BCNT    = 9'h006;
  localparam logic [8:0]  MRS_POS_DATA    = 9'h007;
  localparam logic [8:0]  MRS_POS_SAT     = 9'h1FF;
  localparam logic [8:0]  MRS_LEN_STD     = 9'h006;
  localparam logic [8:0]  MRS_LEN_SHORT   = 9'h002;
  localparam logic [8:0]  MRS_LEN_RSP_HDR = 9'h003;
  localparam logic [8:0]  MRS_BC_ZERO     = 9'h100;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] MRS_REG_RST     = 16'h0000;
  localparam logic [7:0]  MRS_STATION_RST = 8'h01;

  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  func;
    logic [15:0] f1;
    logic [15:0] f2;
    logic [7:0]  bcnt;
  } mrs_hdr_s;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } mrs_tx_s;

endpackage

/* core/mrs_rx_parse.sv */
`timescale 1ns/1ps
module mrs_rx_parse
  import mrs_pkg::*;
(
  input  wire logic     clk_sys_i,   // System clock
  input  wire logic     rst_i,       // Sync reset
  input  wire logic     rx_valid_i,  // Query byte strobe
  input  wire logic [7:0] rx_data_i, // Query byte
  input  wire logic     rx_last_i,   // Final byte of frame
  output mrs_hdr_s      hdr_o,       // Decoded header fields
  output logic          dat_valid_o, // Packed data byte strobe
  output logic [7:0]    dat_o,       // Packed data byte
  output logic [7:0]    dat_idx_o,   // Index of data byte
  output logic          done_o,      // Frame complete pulse
  output logic [8:0]    len_o        // Frame length in bytes
);

  mrs_hdr_s   hdr_r, hdr_nxt;
  logic [8:0] pos_r, pos_nxt, len_r, len_nxt;
  logic [7:0] dat_r, dat_nxt, didx_r, didx_nxt;
  logic       dv_r, dv_nxt, done_r, done_nxt;

  always_comb
  begin
    hdr_nxt  = hdr_r;
    pos_nxt  = pos_r;
    len_nxt  = len_r;
    dat_nxt  = dat_r;
    didx_nxt = didx_r;
    dv_nxt   = 1'b0;
    done_nxt = 1'b0;
    if (rx_valid_i)
    begin
      case (pos_r)
        MRS_POS_ADDR:  hdr_nxt.addr     = rx_data_i;
        MRS_POS_FUNC:  hdr_nxt.func     = rx_data_i;
        MRS_POS_F1_HI: hdr_nxt.f1[15:8] = rx_data_i;
        MRS_POS_F1_LO: hdr_nxt.f1[7:0]  = rx_data_i;
        MRS_POS_F2_HI: hdr_nxt.f2[15:8] = rx_data_i;
        MRS_POS_F2_LO: hdr_nxt.f2[7:0]  = rx_data_i;
        MRS_POS_BCNT:  hdr_nxt.bcnt     = rx_data_i;
        default:
        begin
          dv_nxt   = 1'b1;
          dat_nxt  = rx_data_i;
          didx_nxt = 8'(pos_r - MRS_POS_DATA);
        end
      endcase
      // Saturate so an overlong frame fails the length check
      pos_nxt = (pos_r == MRS_POS_SAT) ? pos_r : pos_r + 9'h001;
      if (rx_last_i)
      begin
        done_nxt = 1'b1;
        len_nxt  = pos_nxt;
        pos_nxt  = MRS_POS_ADDR;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      hdr_r  <= '0;
      pos_r  <= MRS_POS_ADDR;
      len_r  <= '0;
      dat_r  <= '0;
      didx_r <= '0;
      dv_r   <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      hdr_r  <= hdr_nxt;
      pos_r  <= pos_nxt;
      len_r  <= len_nxt;
      dat_r  <= dat_nxt;
      didx_r <= didx_nxt;
      dv_r   <= dv_nxt;
      done_r <= done_nxt;
    end
  end

  assign hdr_o       = hdr_r;
  assign dat_valid_o = dv_r;
  assign dat_o       = dat_r;
  assign dat_idx_o   = didx_r;
  assign done_o      = done_r;
  assign len_o       = len_r;

endmodule

/* core/mrs_func_handler.sv */
`timescale 1ns/1ps
module mrs_func_handler
  import mrs_pkg::*;
#(
  parameter logic [7:0] STATION_ADDR = MRS_STATION_RST
)
(
  input  wire logic                   clk_sys_i,      // System clock
  input  wire logic                   rst_i,          // Sync reset
  input  wire logic                   rx_valid_i,     // Query byte strobe
  input  wire logic [7:0]             rx_data_i,      // Query byte
  input  wire logic                   rx_last_i,      // Final byte of frame
  output logic                        tx_valid_o,     // Response byte valid
  output logic [7:0]                  tx_data_o,      // Response byte
  output logic                        tx_last_o,      // Final response byte
  input  wire logic                   tx_ready_i,     // Framer takes byte
  output logic                        exc_valid_o,    // Error response pulse
  output logic [7:0]                  exc_func_o,     // Function in error
  output logic                        listen_only_o,  // Listen-only active
  output logic [6:0]                  ai_idx_o,       // Analog input select
  input  wire logic [15:0]            ai_val_i,       // Analog input value
  input  wire logic                   sweep_i,        // Sweep start pulse
  input  wire logic                   prog_coil_we_i, // Program writes outputs
  input  wire logic [MRS_NUM_OUT-1:0] prog_coils_i,   // Program output values
  output logic [MRS_NUM_OUT-1:0]      coils_o,        // Outputs at sweep start
  input  wire logic [5:0]             reg_rd_idx_i,   // Register read select
  output logic [15:0]                 reg_rd_val_o    // Register read value
);

  // ****************************************
  // Query capture
  // ****************************************
  mrs_hdr_s   hdr_live;
  logic       dat_valid, frame_done;
  logic [7:0] dat_byte, dat_idx;
  logic [8:0] frame_len;

  mrs_rx_parse u_parse (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .rx_valid_i  (rx_valid_i),
    .rx_data_i   (rx_data_i),
    .rx_last_i   (rx_last_i),
    .hdr_o       (hdr_live),
    .dat_valid_o (dat_valid),
    .dat_o       (dat_byte),
    .dat_idx_o   (dat_idx),
    .done_o      (frame_done),
    .len_o       (frame_len)
  );

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_SEND = 3'b100
  } mrs_state_e;

  mrs_state_e state_r, state_nxt;
  mrs_hdr_s   hdr_q_r, hdr_q_nxt;
  mrs_tx_s    tx_r, tx_nxt;
  logic [8:0] len_q_r, len_q_nxt, tx_len_r, tx_len_nxt, tx_idx_r, tx_idx_nxt;
  logic       tx_valid_r, tx_valid_nxt, listen_r, listen_nxt;
  logic       exc_r, exc_nxt;
  logic [7:0] exc_func_r, exc_func_nxt;
  logic       wr_single, wr_multi, wr_reg;
  logic [MRS_NUM_OUT-1:0] coil_r, coil_nxt, pend_r, pend_nxt;
  logic [MRS_NUM_OUT-1:0] coils_out_r, coils_out_nxt;
  logic [15:0] regs_r [MRS_NUM_REG];
  logic [15:0] regs_nxt [MRS_NUM_REG];
  logic [15:0] reg_rd_r, reg_rd_nxt;

  // ****************************************
  // Query checks
  // ****************************************
  logic        bcast, addr_hit, is_restart;
  logic [16:0] end_pt, bc_need;
  logic [8:0]  bc9, len15;
  logic [7:0]  d1, d2;

  assign d1         = hdr_q_r.f2[15:8];
  assign d2         = hdr_q_r.f2[7:0];
  assign bcast      = (hdr_q_r.addr == 8'h00);
  assign addr_hit   = bcast || (hdr_q_r.addr == STATION_ADDR);
  assign is_restart = (hdr_q_r.func == MRS_FN_DIAG) && (hdr_q_r.f1 == MRS_DG_RESTART);
  assign end_pt     = {1'b0, hdr_q_r.f1} + {1'b0, hdr_q_r.f2};
  assign bc9        = (hdr_q_r.bcnt == 8'h00) ? MRS_BC_ZERO : {1'b0, hdr_q_r.bcnt};
  assign bc_need    = ({1'b0, hdr_q_r.f2} + 17'h00007) >> 3;
  assign len15      = MRS_POS_DATA + bc9;

  // ****************************************
  // Control and response sequencing
  // ****************************************
  always_comb
  begin
    logic       bad;
    logic       ok;
    logic       quiet;
    logic [8:0] rsp_len;
    logic [8:0] k;
    logic [7:0] b;
    bad          = 1'b0;
    ok           = 1'b0;
    quiet        = 1'b0;
    rsp_len      = MRS_LEN_STD;
    k            = tx_idx_r - MRS_LEN_RSP_HDR;
    b            = 8'h00;
    state_nxt    = state_r;
    hdr_q_nxt    = hdr_q_r;
    len_q_nxt    = len_q_r;
    listen_nxt   = listen_r;
    exc_nxt      = 1'b0;
    exc_func_nxt = exc_func_r;
    tx_len_nxt   = tx_len_r;
    tx_idx_nxt   = tx_idx_r;
    tx_valid_nxt = tx_valid_r;
    tx_nxt       = tx_r;
    wr_single    = 1'b0;
    wr_multi     = 1'b0;
    wr_reg       = 1'b0;
    ai_idx_o     = 7'(hdr_q_r.f1 + {8'h00, k[8:1]});
    unique case (state_r)
      ST_IDLE:
      begin
        if (frame_done)
        begin
          hdr_q_nxt = hdr_live;
          len_q_nxt = frame_len;
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        state_nxt  = ST_IDLE;
        tx_idx_nxt = 9'h000;
        if (addr_hit && (!listen_r || is_restart))
        begin
          case (hdr_q_r.func)
            MRS_FN_RD_AI:
            begin
              if (!bcast && len_q_r == MRS_LEN_STD)
              begin
                bad     = (hdr_q_r.f2 == 16'h0000) || (hdr_q_r.f2 > MRS_MAX_AI_CNT)
                          || (end_pt > 17'(MRS_NUM_AI));
                ok      = !bad;
                rsp_len = MRS_LEN_RSP_HDR + {hdr_q_r.f2[7:0], 1'b0};
              end
            end
            MRS_FN_FORCE1:
            begin
              if (len_q_r == MRS_LEN_STD)
              begin
                bad       = !(d1 == MRS_DATA_OFF || d1 == MRS_DATA_ON) || d2 != 8'h00
                            || (hdr_q_r.f1 >= 16'(MRS_NUM_OUT));
                ok        = !bad;
                wr_single = ok;
              end
            end
            MRS_FN_PRESET1:
            begin
              if (len_q_r == MRS_LEN_STD)
              begin
                bad    = hdr_q_r.f1 >= 16'(MRS_NUM_REG);
                ok     = !bad;
                wr_reg = ok;
              end
            end
            MRS_FN_EXC_ST:
            begin
              ok      = !bcast && len_q_r == MRS_LEN_SHORT;
              rsp_len = MRS_LEN_RSP_HDR;
            end
            MRS_FN_DIAG:
            begin
              if (len_q_r == MRS_LEN_STD)
              begin
                case (hdr_q_r.f1)
                  MRS_DG_ECHO:    ok = !bcast;
                  MRS_DG_RESTART:
                  begin
                    listen_nxt = 1'b0;
                    bad        = !(d1 == MRS_DATA_OFF || d1 == MRS_DATA_ON) || d2 != 8'h00;
                    ok         = !bad;
                  end
                  MRS_DG_LISTEN:
                  begin
                    quiet = 1'b1;
                    if (hdr_q_r.f2 == 16'h0000)
                      listen_nxt = 1'b1;
                  end
                  default:        quiet = 1'b1;
                endcase
              end
            end
            MRS_FN_FORCE_N:
            begin
              if (len_q_r == len15)
              begin
                bad      = (hdr_q_r.f2 == 16'h0000) || (end_pt > 17'(MRS_NUM_OUT))
                           || (bc_need != 17'(bc9));
                ok       = !bad;
                wr_multi = ok;
              end
            end
            default:       quiet = 1'b1;
          endcase
          if (ok && !bcast && !quiet)
          begin
            state_nxt  = ST_SEND;
            tx_len_nxt = rsp_len;
          end
          if (bad && !bcast)
          begin
            exc_nxt      = 1'b1;
            exc_func_nxt = hdr_q_r.func;
          end
        end
      end
      ST_SEND:
      begin
        if (!tx_valid_r || tx_ready_i)
        begin
          if (tx_idx_r < tx_len_r)
          begin
            case (tx_idx_r)
              9'h000:  b = hdr_q_r.addr;
              9'h001:  b = hdr_q_r.func;
              9'h002:  b = (hdr_q_r.func == MRS_FN_RD_AI) ? {hdr_q_r.f2[6:0], 1'b0} :
                           (hdr_q_r.func == MRS_FN_EXC_ST) ? coil_r[7:0] : hdr_q_r.f1[15:8];
              default:
              begin
                if (hdr_q_r.func == MRS_FN_RD_AI)
                  b = k[0] ? ai_val_i[7:0] : ai_val_i[15:8];
                else if (tx_idx_r == 9'h003)
                  b = hdr_q_r.f1[7:0];
                else
                  b = (tx_idx_r == 9'h004) ? hdr_q_r.f2[15:8] : hdr_q_r.f2[7:0];
              end
            endcase
            tx_nxt.data  = b;
            tx_nxt.last  = (tx_idx_r == tx_len_r - 9'h001);
            tx_valid_nxt = 1'b1;
            tx_idx_nxt   = tx_idx_r + 9'h001;
          end
          else
          begin
            tx_valid_nxt = 1'b0;
            state_nxt    = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_r    <= ST_IDLE;
      hdr_q_r    <= '0;
      len_q_r    <= '0;
      listen_r   <= 1'b0;
      exc_r      <= 1'b0;
      exc_func_r <= 8'h00;
      tx_len_r   <= '0;
      tx_idx_r   <= '0;
      tx_valid_r <= 1'b0;
      tx_r       <= '0;
    end
    else
    begin
      state_r    <= state_nxt;
      hdr_q_r    <= hdr_q_nxt;
      len_q_r    <= len_q_nxt;
      listen_r   <= listen_nxt;
      exc_r      <= exc_nxt;
      exc_func_r <= exc_func_nxt;
      tx_len_r   <= tx_len_nxt;
      tx_idx_r   <= tx_idx_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_r       <= tx_nxt;
    end
  end

  // ****************************************
  // Output point table
  // ****************************************
  // Multiple force data is staged and only committed once the whole query checks out
  for (genvar j = 0; j < MRS_NUM_OUT; j++)
  begin : g_pt
    localparam logic [15:0] PT = 16'(j);
    always_comb
    begin
      logic [15:0] off_l;
      logic [15:0] off_q;
      logic        in_q;
      off_l       = PT - hdr_live.f1;
      off_q       = PT - hdr_q_r.f1;
      in_q        = (PT >= hdr_q_r.f1) && (off_q < hdr_q_r.f2);
      pend_nxt[j] = pend_r[j];
      if (dat_valid && PT >= hdr_live.f1 && off_l[15:3] == {5'h00, dat_idx})
        pend_nxt[j] = dat_byte[off_l[2:0]];
      // A query force wins over a program write in the same cycle
      if (wr_multi && in_q)
        coil_nxt[j] = pend_r[j];
      else if (wr_single && hdr_q_r.f1 == PT)
        coil_nxt[j] = d1[0];
      else if (prog_coil_we_i)
        coil_nxt[j] = prog_coils_i[j];
      else
        coil_nxt[j] = coil_r[j];
    end
  end

  // Outputs seen by the program are sampled only at sweep start
  assign coils_out_nxt = sweep_i ? coil_r : coils_out_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      coil_r      <= '0;
      pend_r      <= '0;
      coils_out_r <= '0;
    end
    else
    begin
      coil_r      <= coil_nxt;
      pend_r      <= pend_nxt;
      coils_out_r <= coils_out_nxt;
    end
  end

  // ****************************************
  // Holding registers
  // ****************************************
  always_comb
  begin
    regs_nxt = regs_r;
    if (wr_reg)
      regs_nxt[6'(hdr_q_r.f1)] = hdr_q_r.f2;
    reg_rd_nxt = regs_r[reg_rd_idx_i];
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      regs_r   <= '{default: MRS_REG_RST};
      reg_rd_r <= MRS_REG_RST;
    end
    else
    begin
      regs_r   <= regs_nxt;
      reg_rd_r <= reg_rd_nxt;
    end
  end

  assign tx_valid_o    = tx_valid_r;
  assign tx_data_o     = tx_r.data;
  assign tx_last_o     = tx_r.last;
  assign exc_valid_o   = exc_r;
  assign exc_func_o    = exc_func_r;
  assign listen_only_o = listen_r;
  assign coils_o       = coils_out_r;
  assign reg_rd_val_o  = reg_rd_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [8:0] shown_idx;
  assign shown_idx = tx_idx_r - 9'h001;

  sequence s_exec_hit;
    state_r == ST_EXEC && addr_hit && (!listen_r || is_restart);
  endsequence

  sequence s_diag_listen;
    s_exec_hit ##0 (hdr_q_r.func == MRS_FN_DIAG && hdr_q_r.f1 == MRS_DG_LISTEN && hdr_q_r.f2 == 16'h0000 &&
                    len_q_r == MRS_LEN_STD);
  endsequence

  listen_quiet_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tx_valid_o |-> !listen_r) else $error("byte sent in listen-only mode");
  ai_byte_count_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_valid_o && hdr_q_r.func == MRS_FN_RD_AI && shown_idx == 9'h002)
    |-> (tx_data_o >= 8'h02 && tx_data_o <= 8'hFA && tx_data_o == {hdr_q_r.f2[6:0], 1'b0}))
    else $error("analog byte count wrong");
  bcast_silent_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r == ST_SEND |-> hdr_q_r.addr != 8'h00) else $error("reply to broadcast");
  err_not_bcast_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    exc_valid_o |-> $past(state_r) == ST_EXEC && hdr_q_r.addr != 8'h00) else $error("error on broadcast");
  listen_enter_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_diag_listen |=> listen_r && state_r == ST_IDLE [*2]) else $error("listen-only not entered");
  restart_leave_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_exec_hit ##0 is_restart && len_q_r == MRS_LEN_STD) |=> !listen_r) else $error("listen-only not left");
  force_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_exec_hit ##0 wr_single) |=> coil_r[8'(hdr_q_r.f1)] == d1[0]) else $error("single force lost");
  preset_reg_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_exec_hit ##0 wr_reg) |=> regs_r[6'(hdr_q_r.f1)] == hdr_q_r.f2) else $error("preset value lost");
  echo_func_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (tx_valid_o && hdr_q_r.func == MRS_FN_FORCE1 && shown_idx == 9'h004) |-> tx_data_o == d1)
    else $error("single force echo wrong");

endmodule

/* tb/mrs_master_model.sv */
`timescale 1ns/1ps
// ****
// Master side: takes reply bytes, stalls at random
// ****
module mrs_master_model
(
  input  wire logic       clk_sys_i,  // System clock
  input  wire logic       tx_valid_i, // Reply byte valid
  input  wire logic [7:0] tx_data_i,  // Reply byte
  input  wire logic       tx_last_i,  // Final reply byte
  output logic            tx_ready_o  // Byte taken
);
  logic [7:0] rsp_q[$];
  int         seed = 32'h3f0ef28c;
  int         frames = 0;

  // Stalls often so held bytes are seen across cycles
  always @(negedge clk_sys_i) tx_ready_o <= ($random(seed) % 3) != 0;

  always @(posedge clk_sys_i)
    if (tx_valid_i === 1'b1 && tx_ready_o)
    begin
      rsp_q.push_back(tx_data_i);
      if (tx_last_i === 1'b1)
        frames++;
    end
endmodule

/* tb/test_mrs_func_handler.sv */
`timescale 1ns/1ps
module test_mrs_func_handler
  import mrs_pkg::*;
;
  logic                   clk_sys_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   rx_valid = 1'b0;
  logic [7:0]             rx_data = 8'h00;
  logic                   rx_last = 1'b0;
  logic                   sweep = 1'b0;
  logic [5:0]             reg_idx = 6'h00;
  logic                   prog_we = 1'b0;
  logic [MRS_NUM_OUT-1:0] prog_coils = '0;
  logic                   tx_valid, tx_last, tx_ready, exc_valid, listen_only;
  logic [7:0]             tx_data, exc_func;
  logic [6:0]             ai_idx;
  logic [15:0]            ai_tab [128];
  logic [15:0]            reg_val, v, v0;
  logic [MRS_NUM_OUT-1:0] coils;
  logic [7:0]             q[$], e[$], z[$];
  int                     seed, s, n;
  int                     failures = 0, cmp_count = 0, exc_n = 0;

  initial forever #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (exc_valid === 1'b1) exc_n++;

  mrs_func_handler DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_last_i(rx_last), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_ready_i(tx_ready),
    .exc_valid_o(exc_valid), .exc_func_o(exc_func), .listen_only_o(listen_only), .ai_idx_o(ai_idx),
    .ai_val_i(ai_tab[ai_idx]), .sweep_i(sweep), .prog_coil_we_i(prog_we), .prog_coils_i(prog_coils),
    .coils_o(coils), .reg_rd_idx_i(reg_idx), .reg_rd_val_o(reg_val));
  mrs_master_model u_mst (.clk_sys_i(clk_sys_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_last_i(tx_last), .tx_ready_o(tx_ready));

  // ****
  // Shared tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Waits out the whole reply, then compares bytes and error pulses
  task automatic txn(input string nm, input logic [7:0] qq[$], input logic [7:0] ee[$], input int xe);
    int f0;
    int x0;
    f0 = u_mst.frames;
    x0 = exc_n;
    u_mst.rsp_q.delete();
    foreach (qq[i])
    begin
      @(negedge clk_sys_i);
      rx_valid = 1'b1;
      rx_data = qq[i];
      rx_last = (i == qq.size() - 1);
    end
    @(negedge clk_sys_i);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    for (int k = 0; k < 800 && u_mst.frames == f0; k++)
      @(negedge clk_sys_i);
    repeat (4) @(negedge clk_sys_i);
    chk({nm, "_len"}, 16'(u_mst.rsp_q.size()), 16'(ee.size()));
    foreach (ee[i])
      chk({nm, "_byte"}, {8'h00, u_mst.rsp_q[i]}, {8'h00, ee[i]});
    chk({nm, "_exc"}, 16'(exc_n - x0), 16'(xe));
    $display("test %s done", nm);
  endtask

  task automatic rd_reg(input logic [5:0] idx, input logic [15:0] exp);
    reg_idx = idx;
    repeat (2) @(negedge clk_sys_i);
    chk("reg_val", reg_val, exp);
  endtask

  task automatic do_sweep();
    @(negedge clk_sys_i);
    sweep = 1'b1;
    @(negedge clk_sys_i);
    sweep = 1'b0;
    @(negedge clk_sys_i);
  endtask

  // ****
  // Scenarios
  // ****
  initial
  begin
    seed = 32'h3f0ef28c;
    foreach (ai_tab[i])
      ai_tab[i] = 16'($random(seed));
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    v0 = 16'($random(seed));
    q = '{8'h01, 8'h06, 8'h00, 8'h05, v0[15:8], v0[7:0]};
    txn("preset", q, q, 0);
    rd_reg(6'h05, v0);
    q = '{8'h00, 8'h06, 8'h00, 8'h07, v0[7:0], v0[15:8]};
    txn("preset_bc", q, z, 0);
    rd_reg(6'h07, {v0[7:0], v0[15:8]});
    q = '{8'h01, 8'h05, 8'h00, 8'h09, 8'hFF, 8'h00};
    txn("force1", q, q, 0);
    chk("pre_sweep", 16'(coils[9]), 16'h0000);
    do_sweep();
    chk("coil10", 16'(coils[9]), 16'h0001);
    q[4] = 8'h12;
    txn("force1_bad", q, z, 1);
    v = 16'($random(seed));
    q = '{8'h01, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h02, v[7:0], {6'h00, v[9:8]}};
    txn("force_n", q, q[0:5], 0);
    do_sweep();
    chk("coils_n", 16'(coils[9:0]), {6'h00, v[9:0]});
    // Program overwrite shows only after the next sweep
    prog_coils = {8{$random(seed)}};
    prog_we = 1'b1;
    @(negedge clk_sys_i);
    prog_we = 1'b0;
    chk("prog_held", 16'(coils[9:0]), {6'h00, v[9:0]});
    do_sweep();
    chk("prog_coils", coils[15:0], prog_coils[15:0]);
    q = '{8'h01, 8'h0F, 8'h00, 8'hFF, 8'h00, 8'h02, 8'h01, 8'h03};
    txn("force_n_rng", q, z, 1);
    q = '{8'h01, 8'h07};
    e = '{8'h01, 8'h07, prog_coils[7:0]};
    txn("exc_stat", q, e, 0);
    for (int c = 0; c < 3; c++)
    begin
      n = (c == 0) ? 125 : 1 + {$random(seed)} % 8;
      s = (c == 0) ? 3 : {$random(seed)} % 100;
      q = '{8'h01, 8'h04, 8'h00, 8'(s), 8'h00, 8'(n)};
      e = '{8'h01, 8'h04, 8'(2 * n)};
      for (int i = 0; i < n; i++)
      begin
        e.push_back(ai_tab[s + i][15:8]);
        e.push_back(ai_tab[s + i][7:0]);
      end
      txn("read_ai", q, e, 0);
    end
    q = '{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h7E};
    txn("ai_cnt", q, z, 1);
    q = '{8'h01, 8'h04, 8'h00, 8'h04, 8'h00, 8'h7D};
    txn("ai_rng", q, z, 1);
    chk("exc_func", {8'h00, exc_func}, 16'h0004);
    q[0] = 8'h00;
    txn("ai_bc", q, z, 0);
    q = '{8'h01, 8'h08, 8'h00, 8'h00, v[15:8], v[7:0]};
    txn("diag_echo", q, q, 0);
    q[3] = 8'h02;
    txn("diag_rsvd", q, z, 0);
    q = '{8'h00, 8'h08, 8'h00, 8'h04, 8'h00, 8'h00};
    txn("listen", q, z, 0);
    chk("listen_on", 16'(listen_only), 16'h0001);
    q = '{8'h01, 8'h06, 8'h00, 8'h05, 8'h00, 8'h00};
    txn("muted", q, z, 0);
    rd_reg(6'h05, v0);
    q = '{8'h01, 8'h08, 8'h00, 8'h01, 8'hFF, 8'h00};
    txn("restart", q, q, 0);
    chk("listen_off", 16'(listen_only), 16'h0000);
    q[4] = 8'h12;
    txn("restart_bad", q, z, 1);
    q = '{8'h01, 8'h08, 8'h00, 8'h04, 8'h00, 8'h00};
    txn("listen_again", q, z, 0);
    // Mid-run reset stands in for power-up
    rst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk("listen_rst", 16'(listen_only), 16'h0000);
    q = '{8'h01, 8'h08, 8'h00, 8'h00, v[7:0], v[15:8]};
    txn("post_rst", q, q, 0);
    tally_and_finish();
  end

  // Whole run needs well under 30k cycles
  initial
  begin
    #400us;
    failures++;
    tally_and_finish();
  end
endmodule
